// *** shared/pwmtb_regs.vh ***
// register map, field positions, reset values and timing constants of the pwm master time bases
`ifndef PWMTB_REGS_VH
`define PWMTB_REGS_VH

// byte addresses of the registers (word aligned)
`define PWMTB_ADDR_PTB_CTRL 6'h00
`define PWMTB_ADDR_PTB_DIV 6'h04
`define PWMTB_ADDR_PTB_PER 6'h08
`define PWMTB_ADDR_PTB_CMP 6'h0c
`define PWMTB_ADDR_STB_CTRL 6'h10
`define PWMTB_ADDR_STB_DIV 6'h14
`define PWMTB_ADDR_STB_PER 6'h18
`define PWMTB_ADDR_STB_CMP 6'h1c

// control register fields
`define PWMTB_BIT_MODULE_ON 15
`define PWMTB_BIT_PENDING 12
`define PWMTB_BIT_IRQ_EN 11
`define PWMTB_BIT_IMM_LOAD 10
`define PWMTB_BIT_SYNC_POL 9
`define PWMTB_BIT_SYNC_OEN 8
`define PWMTB_BIT_SYNC_EN 7
`define PWMTB_SRC_HI 6
`define PWMTB_SRC_LO 4
`define PWMTB_PS_HI 3
`define PWMTB_PS_LO 0

// writable masks: unimplemented bits ignore writes and read zero
`define PWMTB_MASK_PTB_CTRL 16'h8fff
`define PWMTB_MASK_STB_CTRL 16'h0fff
`define PWMTB_MASK_DIV 16'h0007
`define PWMTB_MASK_CMP 16'hfff8

// reset values
`define PWMTB_RST_PER 16'hfff8
`define PWMTB_RST_ZERO 16'h0000

// prescaler and source select code limits
`define PWMTB_DIV_RESERVED 3'h7
`define PWMTB_SRC_MAX 3'h3

// width of the sync output pulse in system clocks
`define PWMTB_SYNC_PULSE_NS 20
`define PWMTB_CLK_NS 20
`define PWMTB_SYNC_PULSE_CYC ((`PWMTB_SYNC_PULSE_NS + `PWMTB_CLK_NS - 1) / `PWMTB_CLK_NS)

`endif

// *** core/pwmtb_core.v ***
// primary and secondary pwm master time bases with an ahb-lite register slave
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "pwmtb_regs.vh"
//
// Summary of operation
// R1 - primary trigger every postscale-plus-one compare matches
// R2 - software changes settings only while module off
// R3 - software sets period above external sync interval
// R4 - prescaler divides by 1 to 64; 111 reserved
// R5 - primary period sixteen bits, resets to fff8
// R6 - software keeps period within 0010 to fff8
// R7 - periods below 0028 have low bits zero
// R8 - primary compare thirteen bits, low three read zero
// R9 - compare unit is one input clock count
// R10 - secondary pending flag in bit twelve
// R11 - bit eleven gates secondary interrupt request
// R12 - secondary period loads immediately or at boundary
// R13 - polarity bit inverts sync inputs and output
// R14 - sync output driven only while enabled
// R15 - external sync enable lets selected input synchronise
// R16 - source select picks input one to four
// R17 - secondary trigger has its own postscaler
// R18 - secondary prescaler in its own divider register
// R19 - secondary period sixteen bits, resets to fff8
// R20 - secondary compare thirteen bits, low bits zero
// R21 - unimplemented bits ignore writes, read zero
// R22 - module enable starts and stops the module
// R23 - primary pending flag set and cleared by hardware
// R24 - primary period waits for boundary unless immediate
// R25 - counters count zero to period then wrap
// R26 - active sync edge clears secondary counter

module pwmtb_core (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// external sync pins
	input wire [3:0] external_sync_input,
	output reg primary_sync_output,
	output reg primary_sync_output_oe,
	output reg secondary_sync_output,
	output reg secondary_sync_output_oe,
	// time base outputs to pwm generators
	output reg [15:0] primary_master_counter,
	output reg [15:0] secondary_master_counter,
	output reg primary_event_trigger,
	output reg secondary_event_trigger,
	output wire primary_irq_request,
	output wire secondary_irq_request
);

	// ****************************************
	// functions
	// ****************************************

	// prescaler code to terminal count of the divider (divide minus one)
	function [5:0] div_limit;
		input [2:0] code;
		begin
			case (code)
				3'h0: div_limit = 6'h00;
				3'h1: div_limit = 6'h01;
				3'h2: div_limit = 6'h03;
				3'h3: div_limit = 6'h07;
				3'h4: div_limit = 6'h0f;
				3'h5: div_limit = 6'h1f;
				3'h6: div_limit = 6'h3f;
				default: div_limit = 6'h00; // reserved code runs at divide-by-1
			endcase
		end
	endfunction

	// ****************************************
	// register storage
	// ****************************************

	reg [15:0] ptb_ctrl; // primary control, pending bit kept separately
	reg [2:0] ptb_div; // primary prescale code
	reg [15:0] ptb_per; // primary period as written
	reg [15:0] ptb_cmp; // primary compare in bits 15..3
	reg [15:0] stb_ctrl; // secondary control
	reg [2:0] stb_div; // secondary prescale code
	reg [15:0] stb_per; // secondary period as written
	reg [15:0] stb_cmp; // secondary compare in bits 15..3
	reg [1:0] pend; // event pending flags, index 0 primary

	wire module_on = ptb_ctrl[`PWMTB_BIT_MODULE_ON];
	wire [15:0] ctrl [0:1];
	assign ctrl[0] = ptb_ctrl;
	assign ctrl[1] = stb_ctrl;

	// ****************************************
	// ahb-lite slave
	// ****************************************

	reg wr_pend; // a write data phase follows
	reg [5:0] wr_addr; // latched address of the write
	wire take = hsel && hready && htrans[1];

	// zero wait state, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase capture
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wr_pend <= 1'b0;
			wr_addr <= 6'h00;
		end else begin
			wr_pend <= take && hwrite;
			wr_addr <= haddr[5:0];
		end
	end

	// read data registered in the address phase; unmapped reads zero
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			case ({haddr[5:2], 2'b00})
				`PWMTB_ADDR_PTB_CTRL: hrdata <= {16'h0000, ptb_ctrl[15:13], pend[0],
					ptb_ctrl[11:0]}; // [R23]
				`PWMTB_ADDR_PTB_DIV: hrdata <= {29'h0, ptb_div}; // [R21]
				`PWMTB_ADDR_PTB_PER: hrdata <= {16'h0000, ptb_per};
				`PWMTB_ADDR_PTB_CMP: hrdata <= {16'h0000, ptb_cmp}; // [R8]
				`PWMTB_ADDR_STB_CTRL: hrdata <= {16'h0000, 3'h0, pend[1],
					stb_ctrl[11:0]}; // [R10]
				`PWMTB_ADDR_STB_DIV: hrdata <= {29'h0, stb_div};
				`PWMTB_ADDR_STB_PER: hrdata <= {16'h0000, stb_per};
				`PWMTB_ADDR_STB_CMP: hrdata <= {16'h0000, stb_cmp}; // [R20]
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// register writes; masks drop unimplemented and status bits
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ptb_ctrl <= `PWMTB_RST_ZERO;
			ptb_div <= 3'h0; // [R4]
			ptb_per <= `PWMTB_RST_PER; // [R5]
			ptb_cmp <= `PWMTB_RST_ZERO;
			stb_ctrl <= `PWMTB_RST_ZERO;
			stb_div <= 3'h0; // [R18]
			stb_per <= `PWMTB_RST_PER; // [R19]
			stb_cmp <= `PWMTB_RST_ZERO;
		end else if (wr_pend) begin
			case ({wr_addr[5:2], 2'b00})
				`PWMTB_ADDR_PTB_CTRL: ptb_ctrl <= hwdata[15:0] & `PWMTB_MASK_PTB_CTRL; // [R21]
				`PWMTB_ADDR_PTB_DIV: ptb_div <= hwdata[2:0];
				`PWMTB_ADDR_PTB_PER: ptb_per <= hwdata[15:0];
				`PWMTB_ADDR_PTB_CMP: ptb_cmp <= hwdata[15:0] & `PWMTB_MASK_CMP; // [R8]
				`PWMTB_ADDR_STB_CTRL: stb_ctrl <= hwdata[15:0] & `PWMTB_MASK_STB_CTRL;
				`PWMTB_ADDR_STB_DIV: stb_div <= hwdata[2:0]; // [R18]
				`PWMTB_ADDR_STB_PER: stb_per <= hwdata[15:0];
				`PWMTB_ADDR_STB_CMP: stb_cmp <= hwdata[15:0] & `PWMTB_MASK_CMP; // [R20]
				default: ;
			endcase
		end
	end

	// ****************************************
	// external sync input conditioning
	// ****************************************

	// three-stage synchroniser; stage one only feeds stage two
	reg [3:0] sync_s1;
	reg [3:0] sync_s2;
	reg [3:0] sync_s3;
	reg [3:0] sync_lvl; // accepted level once stages two and three agree
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync_s1 <= 4'h0;
			sync_s2 <= 4'h0;
			sync_s3 <= 4'h0;
			sync_lvl <= 4'h0;
		end else begin
			sync_s1 <= external_sync_input;
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
			sync_lvl <= (~(sync_s2 ^ sync_s3) & sync_s2) | ((sync_s2 ^ sync_s3) & sync_lvl);
		end
	end

	// ****************************************
	// time base pair: index 0 primary, 1 secondary
	// ****************************************

	wire [2:0] div_code [0:1];
	wire [15:0] per_reg [0:1];
	wire [15:0] cmp_reg [0:1];
	wire [1:0] sync_hit; // active edge on the selected input, per base
	wire [1:0] wrap; // counter at or above period with tick
	wire [1:0] match; // compare match with tick
	wire [1:0] fire; // postscaled trigger
	assign div_code[0] = ptb_div;
	assign div_code[1] = stb_div;
	assign per_reg[0] = ptb_per;
	assign per_reg[1] = stb_per;
	assign cmp_reg[0] = ptb_cmp;
	assign cmp_reg[1] = stb_cmp;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : tb
			reg [5:0] pre_cnt; // prescaler count
			reg [15:0] cnt; // master counter
			reg [3:0] post_cnt; // compare matches since last trigger
			reg sel_prev; // previous selected sync level after polarity
			reg [15:0] act_per; // active period, one driver per base
			wire [2:0] src = ctrl[gi][`PWMTB_SRC_HI:`PWMTB_SRC_LO];
			// reserved source codes select nothing
			wire sel_raw = (src <= `PWMTB_SRC_MAX) ? sync_lvl[src[1:0]] : 1'b0; // [R16]
			wire sel_lvl = sel_raw ^ ctrl[gi][`PWMTB_BIT_SYNC_POL]; // [R13]
			wire tick = module_on && (pre_cnt == div_limit(div_code[gi])); // [R4]
			assign wrap[gi] = tick && (cnt >= act_per); // [R25]
			assign match[gi] = tick && (cnt == cmp_reg[gi]); // [R9]
			assign sync_hit[gi] = module_on && ctrl[gi][`PWMTB_BIT_SYNC_EN]
				&& sel_lvl && !sel_prev; // [R15]
			assign fire[gi] = match[gi] && (post_cnt == ctrl[gi][`PWMTB_PS_HI:`PWMTB_PS_LO]);

			// prescaler, counter and postscaler; module off holds them cleared
			always @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					pre_cnt <= 6'h00;
					cnt <= 16'h0000;
					post_cnt <= 4'h0;
					sel_prev <= 1'b0;
					act_per <= `PWMTB_RST_PER;
				end else begin
					sel_prev <= sel_lvl;
					if (!module_on) begin
						// stopped module behaves as reset and tracks the period
						pre_cnt <= 6'h00; // [R22]
						cnt <= 16'h0000;
						post_cnt <= 4'h0;
						act_per <= per_reg[gi];
					end else begin
						pre_cnt <= tick ? 6'h00 : pre_cnt + 6'h01;
						if (sync_hit[gi]) begin
							cnt <= 16'h0000; // [R26]
							pre_cnt <= 6'h00;
						end else if (wrap[gi]) begin
							cnt <= 16'h0000; // [R25]
						end else if (tick) begin
							cnt <= cnt + 16'h0001;
						end
						// period takes the new value now or at the cycle boundary
						if (ctrl[gi][`PWMTB_BIT_IMM_LOAD] || wrap[gi] || sync_hit[gi]) begin
							act_per <= per_reg[gi]; // [R12] [R24]
						end
						if (match[gi]) begin
							post_cnt <= fire[gi] ? 4'h0 : post_cnt + 4'h1; // [R1] [R17]
						end
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// triggers, pending flags and sync outputs
	// ****************************************

	// pending flags: set wins; hardware clears while the interrupt enable is low
	// or the module stops, so no software clear can lose an event
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pend <= 2'b00;
			primary_event_trigger <= 1'b0;
			secondary_event_trigger <= 1'b0;
		end else begin
			primary_event_trigger <= fire[0]; // [R1]
			secondary_event_trigger <= fire[1]; // [R17]
			if (fire[0]) begin
				pend[0] <= 1'b1; // [R23]
			end else if (!ptb_ctrl[`PWMTB_BIT_IRQ_EN] || !module_on) begin
				pend[0] <= 1'b0; // [R23]
			end
			if (fire[1]) begin
				pend[1] <= 1'b1; // [R10]
			end else if (!stb_ctrl[`PWMTB_BIT_IRQ_EN] || !module_on) begin
				pend[1] <= 1'b0;
			end
		end
	end

	// interrupt requests gated by their enables
	assign primary_irq_request = pend[0] & ptb_ctrl[`PWMTB_BIT_IRQ_EN];
	assign secondary_irq_request = pend[1] & stb_ctrl[`PWMTB_BIT_IRQ_EN]; // [R11]

	// sync outputs pulse one cycle at each wrap, polarity applied, driven only when enabled
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			primary_sync_output <= 1'b0;
			primary_sync_output_oe <= 1'b0;
			secondary_sync_output <= 1'b0;
			secondary_sync_output_oe <= 1'b0;
		end else begin
			primary_sync_output_oe <= ptb_ctrl[`PWMTB_BIT_SYNC_OEN];
			primary_sync_output <= ptb_ctrl[`PWMTB_BIT_SYNC_OEN]
				& (wrap[0] ^ ptb_ctrl[`PWMTB_BIT_SYNC_POL]);
			secondary_sync_output_oe <= stb_ctrl[`PWMTB_BIT_SYNC_OEN]; // [R14]
			secondary_sync_output <= stb_ctrl[`PWMTB_BIT_SYNC_OEN]
				& (wrap[1] ^ stb_ctrl[`PWMTB_BIT_SYNC_POL]); // [R13] [R14]
		end
	end

	// counters to the generators
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			primary_master_counter <= 16'h0000;
			secondary_master_counter <= 16'h0000;
		end else begin
			primary_master_counter <= tb[0].cnt;
			secondary_master_counter <= tb[1].cnt;
		end
	end

endmodule

// *** verification/pwmtb_properties.sv ***
// concurrent checks on the ports of the pwm master time bases
`timescale 1ns/10ps
module pwmtb_properties (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// bus read data
	input wire [31:0] hrdata,
	// sync pins
	input wire primary_sync_output,
	input wire primary_sync_output_oe,
	input wire secondary_sync_output,
	input wire secondary_sync_output_oe,
	// time base outputs
	input wire [15:0] primary_master_counter,
	input wire [15:0] secondary_master_counter,
	input wire primary_event_trigger,
	input wire secondary_event_trigger,
	input wire primary_irq_request,
	input wire secondary_irq_request
);
	// ****************
	// shorthands
	// ****************
	wire [15:0] pc = primary_master_counter; // primary count
	wire [15:0] sc = secondary_master_counter; // secondary count
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// a trigger is a lone pulse, so no match is ever counted twice
	sequence s_pulse(t); t ##1 !t; endsequence
	// a count only steps up by one or restarts at zero
	sequence s_step(v); v == 16'h0000 || v == $past(v) + 16'h0001; endsequence
	// ****************
	// properties
	// ****************
	property p_ptrig; primary_event_trigger |-> s_pulse(primary_event_trigger); endproperty
	a_ptrig: assert property (p_ptrig) else $error("primary trigger too long");
	property p_strig; secondary_event_trigger |-> s_pulse(secondary_event_trigger); endproperty
	a_strig: assert property (p_strig) else $error("secondary trigger too long");
	property p_psoe; !primary_sync_output_oe |-> !primary_sync_output; endproperty
	a_psoe: assert property (p_psoe) else $error("primary sync driven while off");
	property p_ssoe; !secondary_sync_output_oe |-> !secondary_sync_output; endproperty
	a_ssoe: assert property (p_ssoe) else $error("secondary sync driven while off");
	property p_pcnt; $changed(pc) |-> s_step(pc); endproperty
	a_pcnt: assert property (p_pcnt) else $error("primary count jumped");
	property p_scnt; $changed(sc) |-> s_step(sc); endproperty
	a_scnt: assert property (p_scnt) else $error("secondary count jumped");
	property p_rdhi; hrdata[31:16] == 16'h0000; endproperty
	a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
	property p_pirq; $rose(primary_irq_request) |-> primary_event_trigger; endproperty
	a_pirq: assert property (p_pirq) else $error("primary irq without event");
	property p_sirq; $rose(secondary_irq_request) |-> secondary_event_trigger; endproperty
	a_sirq: assert property (p_sirq) else $error("secondary irq without event");
endmodule
bind pwmtb_core pwmtb_properties u_props (.clk_sys(clk_sys), .nrst(nrst), .hrdata(hrdata),
	.primary_sync_output(primary_sync_output), .primary_sync_output_oe(primary_sync_output_oe),
	.secondary_sync_output(secondary_sync_output),
	.secondary_sync_output_oe(secondary_sync_output_oe),
	.primary_master_counter(primary_master_counter),
	.secondary_master_counter(secondary_master_counter),
	.primary_event_trigger(primary_event_trigger),
	.secondary_event_trigger(secondary_event_trigger),
	.primary_irq_request(primary_irq_request), .secondary_irq_request(secondary_irq_request));

// *** verification/pwmtb_sync_src.sv ***
// behavioural source of the four external sync inputs
`timescale 1ns/10ps
module pwmtb_sync_src (
	// clock and reset
	input wire clk_sys,
	input wire nrst,
	// bench controls
	input wire en,
	input wire pol,
	input wire [1:0] pin,
	// sync lines towards the device
	output logic [3:0] external_sync_input
);
	logic [7:0] cnt; // position in the 200 clock interval
	// interval kept shorter than the programmed period
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt <= 8'h00;
			external_sync_input <= 4'h0;
		end else begin
			cnt <= (cnt == 8'hc7 || !en) ? 8'h00 : cnt + 8'h01;
			// idle at the inactive level, four clocks active on one pin
			external_sync_input <= {4{pol}} ^ ((en && cnt < 8'h04) ? 4'h1 << pin : 4'h0);
		end
	end
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the pwm master time bases
`timescale 1ns/10ps
module testbench;
	// ****************
	// bench signals
	// ****************
	logic clk_sys = 1'b0; // 50 mhz clock
	logic nrst = 1'b0; // low for 20 clocks
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0; // idle between tasks
	logic hwrite = 1'b0;
	logic bsel = 1'b0, s_en = 1'b0, s_pol = 1'b0; // base under test, sync source setup
	logic [1:0] s_pin = 2'h0;
	int err_count = 0, n_checks = 0;
	wire hready, ps_o, ps_oe, ss_o, ss_oe, pt, st, pi, si;
	wire [31:0] hrdata;
	wire [3:0] sy;
	wire trg = bsel ? st : pt; // trigger of the base under test
	logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'hfff8, 16'h0000, 16'h0000, 16'h0000,
		16'hfff8, 16'h0000, 16'h0000}; // values after reset
	logic [15:0] mv [9] = '{16'h8fff, 16'h0007, 16'hffff, 16'hfff8, 16'h0fff, 16'h0007,
		16'hffff, 16'hfff8, 16'h0000}; // values after writing all ones
	pwmtb_core dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(), .hrdata(hrdata), .external_sync_input(sy),
		.primary_sync_output(ps_o), .primary_sync_output_oe(ps_oe),
		.secondary_sync_output(ss_o), .secondary_sync_output_oe(ss_oe),
		.primary_master_counter(), .secondary_master_counter(), .primary_event_trigger(pt),
		.secondary_event_trigger(st), .primary_irq_request(pi), .secondary_irq_request(si));
	pwmtb_sync_src u_src (.clk_sys(clk_sys), .nrst(nrst), .en(s_en), .pol(s_pol),
		.pin(s_pin), .external_sync_input(sy));
	initial forever #10 clk_sys = ~clk_sys;
	// ****************
	// tasks
	// ****************
	// one single transfer; waits out any wait state the slave inserts
	task xfer(input int a, input w, input [31:0] d);
		begin
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			@(posedge clk_sys);
			while (hready !== 1'b1) @(posedge clk_sys);
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge clk_sys);
			while (hready !== 1'b1) @(posedge clk_sys);
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks++;
			if (g !== e) begin
				err_count++;
				$display("[FAIL] %0t got %h expected %h", $time, g, e);
			end
		end
	endtask
	task wr(input int a, input [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rd(input int a, input [15:0] e);
		begin
			xfer(a, 1'b0, 32'h0);
			chk(hrdata, {16'h0000, e});
		end
	endtask
	// set one base up with the module off, start it, time the third trigger
	task run(input b, input [2:0] dv, input [3:0] ps, input [15:0] x, input [15:0] per,
		input int gap);
		int a, c;
		begin
			a = b ? 16 : 0;
			bsel = b;
			wr(0, 0); // settings only change while stopped
			wr(a + 4, dv);
			wr(a + 8, per); // in range, low bits zero
			wr(a + 12, 16'h0008);
			if (b) wr(16, x | ps);
			wr(0, b ? 16'h8000 : 16'h8000 | x | ps);
			for (int k = 0; k < 3; k++) begin
				c = 0;
				do begin
					@(posedge clk_sys);
					c++;
				end while (trg !== 1'b1);
			end
			chk(c, gap);
			chk(b ? si : pi, x[11]);
			chk(b ? ss_oe : ps_oe, x[8]);
			chk(b ? ss_o : ps_o, x[9] & x[8]);
			rd(a, (b ? 16'h0 : 16'h8000) | x | ps | {x[11], 12'h0});
		end
	endtask
	// shorten the period in flight: at once with immediate load, else only after the wrap
	task reload(input b, input imm, input int gap);
		int c;
		begin
			run(b, 0, 0, {5'h0, imm, 10'h0}, 16'h0100, 257);
			wr(b ? 24 : 8, 16'h0010);
			c = 0;
			do begin
				@(posedge clk_sys);
				c++;
			end while (trg !== 1'b1);
			chk(c, gap);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 9; i++) rd(4 * i, rv[i]);
		for (int i = 8; i >= 0; i--) wr(4 * i, 32'hffffffff); // enable last
		for (int i = 0; i < 9; i++) rd(4 * i, mv[i]);
		// every divider and postscale code on both bases
		for (int b = 0; b < 2; b++) begin
			for (int d = 0; d < 8; d++) run(b[0], d[2:0], 0, 16'h0800, 16'h0010, d == 7 ? 17 : 17 << d);
			for (int p = 0; p < 16; p++) run(b[0], 0, p[3:0], p[0] ? 16'h0800 : 0, 16'h0010, 17 * (p + 1));
		end
		// four sources, both polarities, a reserved source and sync off
		for (int i = 0; i < 6; i++) begin
			s_pin <= i[1:0];
			s_pol <= i[0];
			s_en <= 1'b1;
			run(1, 0, 0, {6'h0, i[0], 1'b1, i != 5, i == 4 ? 3'h4 : {1'b0, i[1:0]}, 4'h0},
				16'h0100, i < 4 ? 200 : 257);
		end
		// period reload on both bases, boundary then immediate
		for (int i = 0; i < 4; i++) reload(i[1], i[0], i[0] ? 13 : 253);
		conclude;
	end
	// cuts a hang short
	initial begin
		repeat (80000) @(posedge clk_sys);
		err_count++;
		conclude;
	end
endmodule
